// file: rtl/xbus_chip_select_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "xbus_decode_defs.svh"

// Behaviour
// RULE1 - control resets to 03h, fields read/write
// RULE2 - cleared enable blocks select and output enable
// RULE3 - intc select on pci memory region hits
// RULE4 - intc region defaults fec00000/10, relocatable; code decodes a 20h-byte region
// RULE5 - intc disabled: ignore cycle, no strobes
// RULE6 - never intc select for isa masters
// RULE7 - intc bit switches two shared pins
// RULE8 - extended firmware range forwarded, selects asserted
// RULE9 - top firmware forwarding drives la high ones
// RULE10 - no isa memory in aliased firmware range
// RULE11 - extended disabled: no firmware select there
// RULE12 - lower firmware block and alias selected
// RULE13 - lower disabled: no select, no forwarding
// RULE14 - coprocessor error raises irq13, gates ignore
// RULE15 - mouse bit selects irq12 function
// RULE16 - write protect field gates firmware writes
// RULE17 - keyboard ports 60h/64h select keyboard
// RULE18 - clock ports 70-77h select clock, latch
// RULE19 - reserved bits read zero, ignore writes
module xbus_chip_select_decode
    import xbus_decode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // cycle to decode
    input  wire logic        cyc_valid,
    input  wire logic [31:0] cyc_addr,
    input  wire logic [1:0]  cyc_kind,
    input  wire logic        cyc_from_isa,
    // decode results
    output logic             sub_bus_output_enable_n,
    output logic             intc_chip_select_n,
    output logic             firmware_chip_select_n,
    output logic             keyboard_chip_select_n,
    output logic             clock_chip_select_n,
    output logic             clock_address_latch_enable,
    output logic             forward_to_isa,
    output logic [3:0]       isa_la_high,
    output logic             drive_la_high,
    // coprocessor and mouse
    input  wire logic        fp_error_in_n,
    output logic             irq13_internal,
    output logic             ignore_numeric_error_out_n,
    output logic             mouse_function_select,
    // shared pins, and the coprocessor ignore request
    input  wire logic        shared_in_n,
    output logic             shared_out_n,
    output logic             test_input_n,
    output logic             intc_request_n,
    input  wire logic        pci_reset_n,
    input  wire logic        intc_ack_internal_n,
    input  wire logic        ignore_request
);

    logic [15:0] xbus_decode_control;   // documented control register
    logic [31:0] intc_base;             // relocation of intc region
    logic [`XB_ST_W-1:0] status;        // sticky events
    logic [`XB_ST_W-1:0] mask;          // interrupt mask
    logic        bus_done;              // one-cycle answer phase
    logic        fp_err_q;              // previous fp error level

    // decoded hits
    logic        mem_cyc, is_write, io_cyc;
    logic        hit_intc, hit_ext, hit_low_main, hit_low_alias, hit_kbd, hit_clk;
    logic        en_intc, en_ext, en_low, en_kbd, en_clk, fw_cyc;

    cycle_kind_t kind;

    // inclusive range check used for the firmware memory windows
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    assign kind     = cycle_kind_t'(cyc_kind);
    assign mem_cyc  = cyc_valid && (kind == cyc_mem_read || kind == cyc_mem_write);
    assign io_cyc   = cyc_valid && (kind == cyc_io_read || kind == cyc_io_write);
    assign is_write = (kind == cyc_mem_write) || (kind == cyc_io_write);

    // address windows
    assign hit_intc      = mem_cyc && ((cyc_addr & `XB_INTC_SPAN_MASK) == intc_base); // RULE4
    assign hit_ext       = mem_cyc && in_range(cyc_addr, `XB_EXTFW_LO, `XB_EXTFW_HI);
    assign hit_low_main  = mem_cyc && in_range(cyc_addr, `XB_LOWFW_LO, `XB_LOWFW_HI);
    assign hit_low_alias = mem_cyc && in_range(cyc_addr, `XB_LOWFW_ALIAS_LO, `XB_LOWFW_ALIAS_HI);
    assign hit_kbd       = io_cyc && (cyc_addr[15:0] == `XB_IO_KBD_DATA
                                   || cyc_addr[15:0] == `XB_IO_KBD_CMD);
    assign hit_clk       = io_cyc && ((cyc_addr[15:0] & `XB_IO_CLOCK_MASK) == `XB_IO_CLOCK_BASE);

    // qualified by enables; isa masters never get the intc or extended range
    assign en_intc = hit_intc && !cyc_from_isa && xbus_decode_control[`XB_BIT_INTC]; // RULE3 RULE5 RULE6
    assign en_ext  = hit_ext && !cyc_from_isa && xbus_decode_control[`XB_BIT_EXTFW]; // RULE8 RULE11
    assign en_low  = (hit_low_main || hit_low_alias) && xbus_decode_control[`XB_BIT_LOWFW]; // RULE12 RULE13
    assign en_kbd  = hit_kbd && xbus_decode_control[`XB_BIT_KEYBOARD]; // RULE17
    assign en_clk  = hit_clk && xbus_decode_control[`XB_BIT_CLOCK]; // RULE18
    // writes to firmware only pass with write-protect field set
    assign fw_cyc  = (en_ext || en_low) && (!is_write || xbus_decode_control[`XB_BIT_WRPROT]); // RULE16

    // registered strobes; all outputs come from flip-flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sub_bus_output_enable_n    <= 1'b1;
            intc_chip_select_n         <= 1'b1;
            firmware_chip_select_n     <= 1'b1;
            keyboard_chip_select_n     <= 1'b1;
            clock_chip_select_n        <= 1'b1;
            clock_address_latch_enable <= 1'b0;
            forward_to_isa             <= 1'b0;
            drive_la_high              <= 1'b0;
            isa_la_high                <= 4'h0;
        end else begin
            intc_chip_select_n         <= !en_intc;
            firmware_chip_select_n     <= !fw_cyc;
            keyboard_chip_select_n     <= !en_kbd;
            clock_chip_select_n        <= !en_clk;
            clock_address_latch_enable <= en_clk;
            // output enable only for enabled peripherals
            sub_bus_output_enable_n    <= !(en_intc || fw_cyc || en_kbd || en_clk); // RULE2
            // disabled regions are not forwarded at all
            forward_to_isa             <= en_intc || en_ext || en_low; // RULE13
            // top-of-4g firmware aliases to the top of 16m
            drive_la_high <= en_ext || (en_low && hit_low_alias); // RULE9
            isa_la_high   <= (en_ext || (en_low && hit_low_alias)) ? 4'hf : cyc_addr[23:20];
        end
    end

    // coprocessor error, mouse and shared pin muxing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq13_internal             <= 1'b0;
            ignore_numeric_error_out_n <= 1'b1;
            mouse_function_select      <= 1'b0;
            shared_out_n               <= 1'b1;
            test_input_n               <= 1'b1;
            intc_request_n             <= 1'b1;
            fp_err_q                   <= 1'b0;
        end else begin
            fp_err_q <= !fp_error_in_n;
            irq13_internal <= xbus_decode_control[`XB_BIT_COPROC] && !fp_error_in_n; // RULE14
            // ignore only while the error is present
            ignore_numeric_error_out_n <= !(xbus_decode_control[`XB_BIT_COPROC]
                                            && !fp_error_in_n && ignore_request); // RULE14
            mouse_function_select <= xbus_decode_control[`XB_BIT_MOUSE]; // RULE15
            // shared pins: clear=test in/pci reset, set=intc request/ack
            if (xbus_decode_control[`XB_BIT_INTC]) begin // RULE7
                intc_request_n <= shared_in_n;
                test_input_n   <= 1'b1;
                shared_out_n   <= intc_ack_internal_n;
            end else begin
                intc_request_n <= 1'b1;
                test_input_n   <= shared_in_n;
                shared_out_n   <= pci_reset_n;
            end
        end
    end

    // register writes; reserved bits stay zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xbus_decode_control <= `XB_DECODE_RESET; // RULE1
            intc_base           <= `XB_INTC_BASE_RESET;
            mask                <= '0;
        end else if (avs_write && !avs_waitrequest) begin
            // the write lands at the edge where the master sees waitrequest low
            unique case (avs_address[`XB_ADDR_W-1:0])
                `XB_IDX_DECODE: begin
                    if (avs_byteenable[0])
                        xbus_decode_control[7:0]  <= avs_writedata[7:0] & 8'hf7; // RULE19
                    if (avs_byteenable[1])
                        xbus_decode_control[15:8] <= avs_writedata[15:8] & 8'h01; // RULE19
                end
                `XB_IDX_MASK: begin
                    if (avs_byteenable[0])
                        mask <= avs_writedata[`XB_ST_W-1:0];
                end
                `XB_IDX_INTC_BASE: begin
                    intc_base <= avs_writedata & `XB_INTC_SPAN_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // sticky events; a new event wins over a write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= '0;
        end else begin
            for (int i = 0; i < `XB_ST_W; i++) begin
                logic ev;
                logic clr;
                ev  = (i == `XB_ST_FPERR) ? (!fp_error_in_n && !fp_err_q
                                             && xbus_decode_control[`XB_BIT_COPROC])
                                          : (mem_cyc && hit_intc && !en_intc);
                clr = avs_write && !avs_waitrequest && avs_byteenable[0]
                      && avs_address[`XB_ADDR_W-1:0] == `XB_IDX_STATUS && avs_writedata[i];
                if (ev)
                    status[i] <= 1'b1;
                else if (clr)
                    status[i] <= 1'b0;
            end
        end
    end

    // bus answer: waitrequest high for one cycle, then answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_done        <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
            irq             <= 1'b0;
        end else begin
            irq <= |(status & mask);
            if ((avs_read || avs_write) && !bus_done) begin
                bus_done        <= 1'b1;
                avs_waitrequest <= 1'b0;
                unique case (avs_address[`XB_ADDR_W-1:0])
                    `XB_IDX_DECODE:    avs_readdata <= {16'h0000, xbus_decode_control};
                    `XB_IDX_STATUS:    avs_readdata <= {30'h0, status};
                    `XB_IDX_MASK:      avs_readdata <= {30'h0, mask};
                    `XB_IDX_INTC_BASE: avs_readdata <= intc_base;
                    default:           avs_readdata <= 32'h0000_0000;
                endcase
            end else begin
                bus_done        <= 1'b0;
                avs_waitrequest <= 1'b1;
            end
        end
    end

endmodule // xbus_chip_select_decode
`default_nettype wire

// file: rtl/xbus_decode_defs.svh
`ifndef XBUS_DECODE_DEFS_SVH
`define XBUS_DECODE_DEFS_SVH

// register word addresses (byte address = 4 * index)
`define XB_IDX_DECODE       8'h4e
`define XB_IDX_STATUS       8'h50
`define XB_IDX_MASK         8'h51
`define XB_IDX_INTC_BASE    8'h52
`define XB_ADDR_W           8

// decode control fields
`define XB_BIT_CLOCK        0
`define XB_BIT_KEYBOARD     1
`define XB_BIT_WRPROT       2
`define XB_BIT_MOUSE        4
`define XB_BIT_COPROC       5
`define XB_BIT_LOWFW        6
`define XB_BIT_EXTFW        7
`define XB_BIT_INTC         8
`define XB_DECODE_RESET     16'h0003
`define XB_DECODE_WMASK     16'h01f7

// interrupt controller region default and size
`define XB_INTC_BASE_RESET  32'hfec0_0000
`define XB_INTC_SPAN_MASK   32'hffff_ffe0

// firmware regions
`define XB_EXTFW_LO         32'hfff8_0000
`define XB_EXTFW_HI         32'hfffd_ffff
`define XB_LOWFW_LO         32'h000e_0000
`define XB_LOWFW_HI         32'h000e_ffff
`define XB_LOWFW_ALIAS_LO   32'hfffe_0000
`define XB_LOWFW_ALIAS_HI   32'hfffe_ffff

// i/o ports
`define XB_IO_KBD_DATA      16'h0060
`define XB_IO_KBD_CMD       16'h0064
`define XB_IO_CLOCK_MASK    16'hfff8
`define XB_IO_CLOCK_BASE    16'h0070

// status bits
`define XB_ST_FPERR         0
`define XB_ST_DENIED        1
`define XB_ST_W             2

`endif

// file: rtl/xbus_decode_pkg.sv
package xbus_decode_pkg;
    // kind of cycle presented on the decode port
    typedef enum logic [1:0] {
        cyc_mem_read,
        cyc_mem_write,
        cyc_io_read,
        cyc_io_write
    } cycle_kind_t;
endpackage

// file: tb/xbus_decode_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches decode strobes and shared pins from the ports only
module xbus_decode_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cyc_valid,
    input wire logic [31:0] cyc_addr,
    input wire logic [1:0]  cyc_kind,
    input wire logic        cyc_from_isa,
    input wire logic        sub_bus_output_enable_n,
    input wire logic        intc_chip_select_n,
    input wire logic        firmware_chip_select_n,
    input wire logic        keyboard_chip_select_n,
    input wire logic        clock_chip_select_n,
    input wire logic        clock_address_latch_enable,
    input wire logic [3:0]  isa_la_high,
    input wire logic        drive_la_high,
    input wire logic        test_input_n,
    input wire logic        intc_request_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a cycle started by an isa master
    sequence s_isa_cyc;
        cyc_valid && cyc_from_isa;
    endsequence
    property p_isa; s_isa_cyc |=> intc_chip_select_n; endproperty
    a_isa: assert property (p_isa) else $error("intc select on isa cycle");
    property p_oe; sub_bus_output_enable_n == (intc_chip_select_n && firmware_chip_select_n
        && keyboard_chip_select_n && clock_chip_select_n); endproperty
    a_oe: assert property (p_oe) else $error("output enable without select");
    property p_ale; clock_address_latch_enable == !clock_chip_select_n; endproperty
    a_ale: assert property (p_ale) else $error("latch enable apart from clock select");
    property p_rtc; !clock_chip_select_n |-> $past(cyc_valid && cyc_kind[1] && cyc_addr[15:3] == 13'h000e);
    endproperty
    a_rtc: assert property (p_rtc) else $error("clock select outside 70-77");
    property p_kbd; !keyboard_chip_select_n |-> $past(cyc_valid && cyc_kind[1]
        && (cyc_addr[15:0] == 16'h0060 || cyc_addr[15:0] == 16'h0064)); endproperty
    a_kbd: assert property (p_kbd) else $error("keyboard select on wrong port");
    property p_fw; !firmware_chip_select_n |-> $past(cyc_valid && !cyc_kind[1]
        && (cyc_addr[31:16] == 16'h000e || cyc_addr[31:16] == 16'hfffe
        || (!cyc_from_isa && cyc_addr >= 32'hfff8_0000 && cyc_addr <= 32'hfffd_ffff))); endproperty
    a_fw: assert property (p_fw) else $error("firmware select outside regions");
    property p_la; drive_la_high |-> isa_la_high == 4'hf; endproperty
    a_la: assert property (p_la) else $error("high address lines not all ones");
    property p_shared; test_input_n || intc_request_n; endproperty
    a_shared: assert property (p_shared) else $error("shared input routed twice");
endmodule // xbus_decode_checker
bind xbus_chip_select_decode xbus_decode_checker u_chk (.*);
`default_nettype wire

// file: tb/cycle_master.sv
`timescale 1ns/1ps
`default_nettype none
// far-side bus master: one memory or i/o cycle at a time
module cycle_master (
    input  wire logic        clk,
    output logic             cyc_valid,
    output logic [31:0]      cyc_addr,
    output logic [1:0]       cyc_kind,
    output logic             cyc_from_isa
);
    initial begin
        cyc_valid = 1'b0;
        cyc_addr = 32'h0000_0000;
        cyc_kind = 2'b00;
        cyc_from_isa = 1'b0;
    end
    // hold n edges so prompt and slow masters are both seen
    task automatic issue(logic [31:0] a, logic [1:0] k, logic isa, int n);
        if (isa && !k[1] && a >= 32'h00f8_0000 && a <= 32'h00fd_ffff) a[24] = 1'b1;
        cyc_valid <= 1'b1;
        cyc_addr <= a;
        cyc_kind <= k;
        cyc_from_isa <= isa;
        repeat (n) @(posedge clk);
    endtask
    // a released bus shows no stale address
    task automatic idle();
        cyc_valid <= 1'b0;
        cyc_addr <= ~cyc_addr;
    endtask
endmodule // cycle_master
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, irq, avs_waitrequest;
    logic [9:0] avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, cyc_addr, q;
    logic [3:0] avs_byteenable = 4'hf, isa_la_high;
    logic [1:0] cyc_kind;
    logic cyc_valid, cyc_from_isa, sub_bus_output_enable_n, intc_chip_select_n, firmware_chip_select_n;
    logic keyboard_chip_select_n, clock_chip_select_n, clock_address_latch_enable, forward_to_isa, drive_la_high;
    logic fp_error_in_n = 1, irq13_internal, ignore_numeric_error_out_n, mouse_function_select;
    logic shared_in_n = 1, shared_out_n, test_input_n, intc_request_n, pci_reset_n = 1;
    logic intc_ack_internal_n = 1, ignore_request = 0;
    logic [31:0] lf = 32'h0000_2e10;
    logic [15:0] c;
    logic [5:0] e;
    int miscompares = 0, total_checks = 0;
    // corner addresses around every decoded window
    logic [31:0] adr [16] = '{32'h0000_0060, 32'h0000_0064, 32'h0000_0070, 32'h0000_0077, 32'h0000_0078,
        32'h0000_0061, 32'h000e_0000, 32'h000e_ffff, 32'hfff8_0000, 32'hfffd_ffff, 32'hfffe_0000,
        32'hfffe_ffff, 32'hfec0_0000, 32'hfec0_0010, 32'hfec0_0020, 32'h000d_ffff};
    wire logic [5:0] seen = ~{sub_bus_output_enable_n, intc_chip_select_n, firmware_chip_select_n,
        keyboard_chip_select_n, clock_chip_select_n, !clock_address_latch_enable};
    xbus_chip_select_decode u_dut (.*);
    cycle_master u_mst (.clk(clk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_kind(cyc_kind),
        .cyc_from_isa(cyc_from_isa));
    always #4 clk = ~clk;
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected {oe, intc, firmware, keyboard, clock, forwarded firmware}
    function automatic logic [5:0] exp_dec(logic [15:0] cc, logic [31:0] a, logic [1:0] k, logic isa);
        logic io, kb, rt, ext, low, fw, ic;
        io = k[1];
        kb = io && cc[1] && (a[15:0] == 16'h0060 || a[15:0] == 16'h0064);
        rt = io && cc[0] && a[15:3] == 13'h000e;
        ext = !io && !isa && cc[7] && a >= 32'hfff8_0000 && a <= 32'hfffd_ffff;
        low = !io && cc[6] && (a[31:16] == 16'h000e || a[31:16] == 16'hfffe);
        fw = (ext || low) && (!k[0] || cc[2]);
        ic = !io && !isa && cc[8] && a[31:5] == 27'h7f6_0000;
        return {kb | rt | fw | ic, ic, fw, kb, rt, ext | low};
    endfunction
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        avs_address <= {2'b00, a};
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            results();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(0, 8'h4e, 0);
        chk("ctrl reset", 32'h0000_0003, q);
        bus(0, 8'h3f, 0);
        chk("unmapped", 0, q);
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            c = i == 0 ? 16'h0003 : i == 1 ? 16'h01f7 : i == 2 ? 16'h0000 : i == 3 ? 16'h0143 : lf[15:0] & 16'h01f7;
            bus(1, 8'h4e, {16'hffff, c | 16'hfe08});
            bus(0, 8'h4e, 0);
            chk("ctrl", {16'h0000, c}, q);
            shared_in_n <= lf[16];
            pci_reset_n <= lf[17];
            intc_ack_internal_n <= lf[18];
            repeat (2) @(posedge clk);
            e = {2'b00, c[8] | lf[16], c[8] ? lf[16] : 1'b1, c[8] ? lf[18] : lf[17], c[4]};
            chk("shared", e, {test_input_n, intc_request_n, shared_out_n, mouse_function_select});
            for (int j = 0; j < 128; j++) begin
                lf = nxt(lf);
                u_mst.issue(adr[j[3:0]], j[5:4], j[6], 2 + lf[1:0]);
                e = exp_dec(c, adr[j[3:0]], j[5:4], j[6]);
                chk("strobes", {e[5:1], e[1]}, seen);
                chk("forward", e[0] | e[4], forward_to_isa);
                if (adr[j[3:0]][31:20] == 12'hfff && !j[6] && !j[5]) chk("la", {e[0], 4'hf}, {drive_la_high, isa_la_high});
            end
            u_mst.idle();
        end
        bus(1, 8'h4e, 32'h0000_0020);
        bus(1, 8'h50, 32'h0000_0003);
        bus(1, 8'h51, 32'h0000_0000);
        fp_error_in_n <= 1'b0;
        ignore_request <= 1'b1;
        repeat (3) @(posedge clk);
        chk("fp on", 3'b100, {irq13_internal, ignore_numeric_error_out_n, irq});
        bus(0, 8'h50, 0);
        chk("status", 1, q[0]);
        bus(1, 8'h51, 1);
        @(posedge clk);
        chk("irq", 1, irq);
        bus(1, 8'h50, 1);
        @(posedge clk);
        chk("irq clr", 0, irq);
        bus(1, 8'h4e, 0);
        @(posedge clk);
        chk("fp off", 2'b01, {irq13_internal, ignore_numeric_error_out_n});
        results();
    end
endmodule // tb_top
`default_nettype wire
